/* File: dac_i2c_params.svh */
`ifndef DAC_I2C_PARAMS_SVH
`define DAC_I2C_PARAMS_SVH
`define GLOBAL_ADDR      7'h73
`define ADDR_HI_BASE     3'h1
`define CMD_WRITE        4'h0
`define CMD_UPDATE       4'h1
`define CMD_WRITE_UPDATE 4'h3
`define CMD_POWER_DOWN   4'h4
`define CMD_NOP          4'hf
`define CODE_ZERO_SCALE  16'h0000
`define CODE_MID_SCALE   16'h8000
`define STRAP_PROBE_CYC  4'h8
`define ACK_BIT_POS      4'h8
`endif

/* File: dac_i2c_pkg.sv */
`default_nettype none
package dac_i2c_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_ACK, ST_IGNORE} bus_state_e;
  typedef enum logic [1:0] {STRAP_LOW, STRAP_FLOAT, STRAP_HIGH} strap_level_e;
endpackage
`default_nettype wire

/* File: dac_i2c_write_slave.sv */
// Behaviour
// - Each strap pin senses low, float or high
// - Address from strap index: hi=t/4+1, lo=t%4
// - Also answer fixed global address 1110011
// - Global write accepted by every device
// - Drive and sense straps during detection, then release
// - SDA released except open-drain ack low
// - Shift SDA in on SCL rising edges
// - SDA fall with SCL high starts transaction
// - SDA rise with SCL high ends transaction
// - Hold ack low through whole SCL high
// - Never acknowledge a read address
// - Load falling edge after full word updates
// - Load low before full word: no update
// - Load low blocks software power down
// - Reset code zero or mid scale by variant
// - Converter code is N-bit unsigned binary
// - Ack three data bytes, then nack extras
// - Decode write, update, both, down, nop
// - Load pulse mid-word powers up only
`timescale 1ns/1ps
`default_nettype none
`include "dac_i2c_params.svh"
module dac_i2c_write_slave
  import dac_i2c_pkg::*;
#(
  parameter int  RES_BITS    = 16,   // Converter resolution
  parameter bit  MID_VARIANT = 1'b0  // Alternate variant resets to mid scale
)(
  input  wire logic                clock,          // 40 MHz system clock
  input  wire logic                nrst,           // Power-on reset, active low
  input  wire logic                scl_in,         // Bus clock pin level
  input  wire logic                sda_in,         // Bus data pin level
  output logic                     sda_out,        // Always low when enabled
  output logic                     sda_oe,         // Pull SDA low when high
  input  wire logic [2:0]          addr_strap_in,  // Strap pins level
  output logic      [2:0]          addr_strap_out, // Strap probe drive value
  output logic      [2:0]          addr_strap_oe,  // Strap probe enable
  input  wire logic                async_load_n,   // Asynchronous load, active low
  output logic      [RES_BITS-1:0] dac_code,       // Converter register
  output logic      [15:0]         input_reg,      // Input register
  output logic                     powered_down,   // Converter powered down
  output logic      [6:0]          slave_addr_bits // Decoded own address
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one feeds only stage two
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sync3 <= 3'h7;
    end
    else
    begin
      sync1 <= {async_load_n, sda_in, scl_in};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  wire scl      = sync2[0];
  wire sda      = sync2[1];
  wire load_n   = sync2[2];
  wire scl_rise = sync2[0] & ~sync3[0];
  wire scl_fall = ~sync2[0] & sync3[0];
  wire start_c  = scl & sync3[0] & ~sync2[1] & sync3[1];
  wire stop_c   = scl & sync3[0] & sync2[1] & ~sync3[1];
  wire load_fall = ~sync2[2] & sync3[2];

  ////////////////////////////////////////////////////////////////////////////
  // Strap probing: drive high then low, sense each; float follows the drive
  logic [3:0] probe_cnt;
  logic [2:0] seen_hi;
  logic [2:0] seen_lo;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [1:0] probe_phase;
  logic       straps_ok;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      probe_cnt   <= 4'h0;
      probe_phase <= 2'h0;
      seen_hi     <= 3'h0;
      seen_lo     <= 3'h0;
      strap_s1    <= 3'h0;
      strap_s2    <= 3'h0;
      straps_ok   <= 1'b0;
    end
    else
    begin
      strap_s1 <= addr_strap_in;
      strap_s2 <= strap_s1;
      if (!straps_ok)
      begin
        probe_cnt <= probe_cnt + 4'h1;
        if (probe_cnt == `STRAP_PROBE_CYC)
        begin
          probe_cnt <= 4'h0;
          if (probe_phase == 2'h0)
            seen_hi <= strap_s2;
          else
            seen_lo <= strap_s2;
          probe_phase <= probe_phase + 2'h1;
          straps_ok   <= (probe_phase == 2'h1);
        end
      end
    end
  end
  assign addr_strap_oe  = straps_ok ? 3'h0 : 3'h7;
  assign addr_strap_out = (probe_phase == 2'h0) ? 3'h7 : 3'h0;

  // Float reads back what was driven; a tied pin reads the same both times
  logic [1:0] lvl [3];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_strap
      assign lvl[gi] = (seen_hi[gi] & ~seen_lo[gi]) ? 2'(STRAP_FLOAT) :
                       seen_hi[gi] ? 2'(STRAP_HIGH) : 2'(STRAP_LOW);
    end
  endgenerate

  wire [4:0] strap_idx = 5'(5'd9 * lvl[2] + 5'd3 * lvl[1] + 5'(lvl[0]));
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      slave_addr_bits <= 7'h00;
    else if (straps_ok)
      slave_addr_bits <= {3'(strap_idx[4:2] + `ADDR_HI_BASE), 2'b00, strap_idx[1:0]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus receiver state machine
  bus_state_e state;
  bus_state_e ret_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [1:0] byte_cnt;
  logic [23:0] word;
  logic       ack_drive;
  logic       word_done;

  wire addr_hit = straps_ok & ~shift[0] &
                  ((shift[7:1] == slave_addr_bits) | (shift[7:1] == `GLOBAL_ADDR));
  wire [7:0] shift_in = {shift[6:0], sda};

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state     <= ST_IDLE;
      ret_state <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      byte_cnt  <= 2'h0;
      word      <= 24'h00_0000;
      ack_drive <= 1'b0;
      word_done <= 1'b0;
    end
    else
    begin
      word_done <= 1'b0;
      if (stop_c)
      begin
        state     <= ST_IDLE;
        ack_drive <= 1'b0;
      end
      else if (start_c)
      begin
        state     <= ST_ADDR;
        bit_cnt   <= 4'h0;
        byte_cnt  <= 2'h0;
        ack_drive <= 1'b0;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_DATA:
          begin
            if (scl_rise && bit_cnt != `ACK_BIT_POS)
            begin
              shift   <= shift_in;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == `ACK_BIT_POS)
            begin
              bit_cnt <= 4'h0;
              state   <= ST_ACK;
              if (state == ST_ADDR)
              begin
                ack_drive <= addr_hit;
                ret_state <= addr_hit ? ST_DATA : ST_IGNORE;
              end
              else
              begin
                ack_drive <= (byte_cnt != 2'h3);
                ret_state <= (byte_cnt != 2'h3) ? ST_DATA : ST_IGNORE;
                if (byte_cnt != 2'h3)
                begin
                  word     <= {word[15:0], shift};
                  byte_cnt <= byte_cnt + 2'h1;
                end
              end
            end
          end
          ST_ACK:
          begin
            // Ack held until SCL falls after its high phase
            if (scl_fall)
            begin
              ack_drive <= 1'b0;
              state     <= ret_state;
              word_done <= (ret_state == ST_DATA) && (byte_cnt == 2'h3);
              if (byte_cnt == 2'h3)
                state <= ST_IGNORE;
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Command execution and converter register
  wire [3:0] command_nibble = word[23:20];
  wire do_write  = (command_nibble == `CMD_WRITE) | (command_nibble == `CMD_WRITE_UPDATE);
  wire do_update = (command_nibble == `CMD_UPDATE) | (command_nibble == `CMD_WRITE_UPDATE);
  wire do_down   = (command_nibble == `CMD_POWER_DOWN);
  wire [15:0] next_input = do_write ? word[15:0] : input_reg;
  wire in_word   = (state != ST_IDLE) & (state != ST_IGNORE);
  logic have_word;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      input_reg    <= 16'h0000;
      dac_code     <= MID_VARIANT ? RES_BITS'(`CODE_MID_SCALE >> (16 - RES_BITS))
                                  : RES_BITS'(`CODE_ZERO_SCALE);
      powered_down <= 1'b0;
      have_word    <= 1'b0;
    end
    else
    begin
      if (!load_n)
        powered_down <= 1'b0;
      if (word_done)
      begin
        have_word <= 1'b1;
        input_reg <= next_input;
        if (do_update || !load_n)
        begin
          dac_code     <= next_input[15 -: RES_BITS];
          powered_down <= 1'b0;
        end
        else if (do_down)
          powered_down <= 1'b1;
      end
      else if (load_fall && have_word && !in_word)
        dac_code <= input_reg[15 -: RES_BITS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_read_no_ack: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_ADDR && scl_fall && bit_cnt == `ACK_BIT_POS && shift[0])
      |=> !sda_oe) else $error("read address acknowledged");
  a_ack_holds: assert property (@(posedge clock) disable iff (!nrst)
    (sda_oe && scl) |=> sda_oe || scl_fall || stop_c || start_c)
      else $error("ack released while SCL high");
  a_no_pd_load: assert property (@(posedge clock) disable iff (!nrst)
    !load_n |=> !powered_down) else $error("power down while load low");
  a_no_early_upd: assert property (@(posedge clock) disable iff (!nrst)
    (!have_word && !word_done) |=> $stable(dac_code)) else $error("update before word");
  a_sda_idle: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_IDLE) |-> !sda_oe) else $error("SDA driven when idle");
  a_extra_nack: assert property (@(posedge clock) disable iff (!nrst)
    (state == ST_IGNORE) |-> !sda_oe) else $error("extra byte acked");
  a_load_upd: assert property (@(posedge clock) disable iff (!nrst)
    (load_fall && have_word && !in_word && !word_done)
      |=> dac_code == $past(input_reg[15 -: RES_BITS])) else $error("load missed");
  a_start_addr: assert property (@(posedge clock) disable iff (!nrst)
    (start_c && !stop_c) |=> state == ST_ADDR) else $error("start missed");
  c_word: cover property (@(posedge clock) disable iff (!nrst) word_done);
  c_load: cover property (@(posedge clock) disable iff (!nrst) load_fall && have_word);
  c_down: cover property (@(posedge clock) disable iff (!nrst) $rose(powered_down));
  // Extra bytes after a full word, or a refused address, are clocked through unanswered
  c_extra: cover property (@(posedge clock) disable iff (!nrst) (state == ST_IGNORE) && scl_rise);

endmodule
`default_nettype wire

/* File: i2c_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////
// Bus master model; SDA has a pull-up, so a released SDA reads high; SCL is driven high and low directly
module i2c_bus_master (
  input  wire logic clock,   // Bench clock
  input  wire logic sda,     // Resolved data line
  output logic      scl,     // Bus clock drive
  output logic      sda_low  // Pull data line low
);
  // Idle bus: both lines high
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Random phase length, never below the 5-clock minimum
  task automatic hold;
    repeat (5 + $urandom % 8) @(posedge clock);
  endtask
  task automatic start;
    sda_low <= 1'b1;
    hold;
    scl <= 1'b0;
    hold;
  endtask
  task automatic stop;
    sda_low <= 1'b1;
    hold;
    scl <= 1'b1;
    hold;
    sda_low <= 1'b0;
    hold;
  endtask
  // Data moves only while the clock is low, MSB first; ack read late in the high phase
  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_low <= ~v[i];
      hold;
      scl <= 1'b1;
      hold;
      scl <= 1'b0;
      hold;
    end
    sda_low <= 1'b0;
    hold;
    scl <= 1'b1;
    hold;
    ack = ~sda;
    scl <= 1'b0;
    hold;
  endtask
endmodule
`default_nettype wire

/* File: dac_i2c_write_slave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dac_i2c_params.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
////////////////////////////////////////
module dac_i2c_write_slave_tb;
  logic        clock  = 1'b0;
  logic        nrst   = 1'b0;
  logic        load_n = 1'b1;
  logic [2:0]  strap_in, strap_out, strap_oe;
  logic [15:0] dac_code, input_reg, mid_code;
  logic [6:0]  addr, own;
  logic        sda_oe, sda_out, powered_down, scl, m_low, ack;
  logic [3:0]  cmds [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hf, 4'h2};
  int          lv [3] = '{0, 0, 0};
  int          miscompares = 0;
  int          compares = 0;
  int          exp_in, exp_dac, exp_pd, any_word, t, ld;
  wire         sda = ~(m_low | (sda_oe & ~sda_out));

  // 25 ns period
  always #12.5 clock = ~clock;

  // Straps: 0 tied low, 2 tied high, 1 floating; undriven float flips, so a probe must drive
  always_comb
  begin
    for (int k = 0; k < 3; k++)
      strap_in[k] = (lv[k] == 1) ? (strap_oe[k] ? strap_out[k] : ~strap_out[k]) : (lv[k] == 2);
  end

  dac_i2c_write_slave #(.RES_BITS(16), .MID_VARIANT(1'b0)) dut (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_in(strap_in), .addr_strap_out(strap_out),
    .addr_strap_oe(strap_oe), .async_load_n(load_n), .dac_code(dac_code),
    .input_reg(input_reg), .powered_down(powered_down), .slave_addr_bits(addr));

  // Alternate variant listens on the same bus but never drives it; only its reset code differs
  dac_i2c_write_slave #(.RES_BITS(16), .MID_VARIANT(1'b1)) dut_mid (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(),
    .sda_oe(), .addr_strap_in(strap_in), .addr_strap_out(),
    .addr_strap_oe(), .async_load_n(load_n), .dac_code(mid_code),
    .input_reg(), .powered_down(), .slave_addr_bits());

  i2c_bus_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(m_low));

  ////////////////////////////////////////
  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Model of a completed word; load low at completion forces an update
  task automatic apply(input logic [3:0] c, input int w, input bit low);
    if (c == 4'h0 || c == 4'h3) exp_in = w;
    if (c == 4'h1 || c == 4'h3 || low) exp_dac = exp_in;
    if (c == 4'h1 || c == 4'h3 || low) exp_pd = 0;
    else if (c == 4'h4) exp_pd = 1;
    any_word = 1;
  endtask

  // Load falling edge; mid-word it only powers up
  task automatic load_edge(input bit mid, input bit keep);
    load_n <= 1'b0;
    if (any_word && !mid) exp_dac = exp_in;
    exp_pd = 0;
    repeat (4) @(posedge clock);
    if (!keep) load_n <= 1'b1;
  endtask

  // Mode 1 keeps load low through the word, mode 2 pulses it before the third data byte
  task automatic xfer(input logic [6:0] a, input logic rw, input logic [3:0] c, input int w,
                      input int n, input int mode);
    logic [7:0] b [4];
    logic       ok;
    b = '{{c, 4'h5}, w[15:8], w[7:0], 8'ha5};
    ok = !rw && (a == own || a == `GLOBAL_ADDR);
    m.start;
    m.put_byte({a, rw}, ack);
    `CHK("addr ack", ok, ack)
    for (int i = 0; i < n; i++)
    begin
      if (mode == 2 && i == 2) load_edge(1, 0);
      m.put_byte(b[i], ack);
      `CHK("data ack", ok && i < 3, ack)
    end
    m.stop;
    if (ok && n >= 3) apply(c, w, mode == 1);
  endtask

  // Reset probes the straps again
  task automatic reset_dut;
    nrst <= 1'b0;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (30) @(posedge clock);
    t = 9 * lv[2] + 3 * lv[1] + lv[0];
    own = {3'(t / 4 + 1), 2'b00, 2'(t % 4)};
    `CHK("address", own, addr)
    `CHK("dac reset", `CODE_ZERO_SCALE, dac_code)
    `CHK("power reset", 1'b0, powered_down)
    `CHK("mid reset", `CODE_MID_SCALE, mid_code)
    `CHK("input reset", 16'h0000, input_reg)
    `CHK("strap release", 3'h0, strap_oe)
    `CHK("sda level", 1'b0, sda_out)
    `CHK("sda idle", 1'b0, sda_oe)
    exp_in = 0;
    exp_dac = 0;
    exp_pd = 0;
    any_word = 0;
  endtask

  task automatic check_regs;
    m.hold;
    `CHK("dac code", 16'(exp_dac), dac_code)
    `CHK("mid code", 16'(exp_dac), mid_code)
    `CHK("input reg", 16'(exp_in), input_reg)
    `CHK("power", 1'(exp_pd), powered_down)
  endtask

  ////////////////////////////////////////
  // Random words per strap setting, then a read, a foreign address and a fourth byte
  initial
  begin
    void'($urandom(89));
    for (int r = 0; r < 3; r++)
    begin
      for (int k = 0; k < 3; k++)
        lv[k] <= $urandom % 3;
      reset_dut;
      for (int i = 0; i < 8; i++)
      begin
        ld = $urandom % 3;
        if (ld != 0) load_edge(0, ld == 1);
        xfer($urandom % 2 ? own : 7'(`GLOBAL_ADDR), 1'b0, i == 0 ? 4'h3 : cmds[$urandom % 6],
             $urandom, 3, ld);
        load_n <= 1'b1;
        check_regs;
      end
      xfer(own, 1'b1, 4'h3, $urandom, 0, 0);
      xfer({own[6:4], 2'b01, own[1:0]}, 1'b0, 4'h3, $urandom, 3, 0);
      xfer(own, 1'b0, 4'h3, $urandom, 4, 0);
      check_regs;
    end
    finish_test;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clock);
    miscompares++;
    finish_test;
  end
endmodule
`default_nettype wire
